// *** src/qnv_pin_if.sv ***
// pin-level front end of the quad serial nvram
`timescale 1ns/100ps
module qnv_pin_if
  import qnv_pkg::*;
(
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // serial pins
  input  wire qnv_pin_in_t  pins_i,
  output qnv_pin_out_t      pins_o,
  // core side: mode and direction
  input  wire qnv_mode_t    mode_i,
  input  wire logic         tx_dir_i,
  // core side: data
  input  wire logic [7:0]   tx_byte_i,
  output logic              tx_take_o,
  output logic      [7:0]   rx_byte_o,
  output logic              rx_valid_o,
  // core side: status
  output logic              sel_o,
  output logic              paused_o,
  output logic              wr_protect_o,
  // core side: store control
  input  wire logic         store_busy_i,
  input  wire logic         store_done_i,
  output logic              hw_store_req_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // bits moved per serial clock in each mode
  function automatic logic [3:0] lanes(input qnv_mode_t m);
    unique case (m)
      QNV_SINGLE: lanes = 4'd1;
      QNV_DUAL:   lanes = 4'd2;
      QNV_QUAD:   lanes = 4'd4;
      default:    lanes = 4'd1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------
  qnv_pin_in_t s;
  logic        sck_prev_q;
  logic        hsb_prev_q;

  qnv_sync #(
    .W       ($bits(qnv_pin_in_t)),
    .RST_VAL (PIN_IN_RST)
  ) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (pins_i),
    .q_o    (s)
  );

  // previous levels for edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sck_prev_q <= 1'b0;
      hsb_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= s.sck;
      hsb_prev_q <= s.store_busy_pin;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic active;
  logic pause;

  // edges by level change serve clock idle low or high
  assign sck_rise = s.sck & ~sck_prev_q;
  assign sck_fall = ~s.sck & sck_prev_q;
  assign active   = ~s.cs_n;
  // pause pin only in single and dual modes
  assign pause    = active & (mode_i != QNV_QUAD) & ~s.io[LINE_THREE];

  // ---------------------------------------------------------------
  // shift group
  // ---------------------------------------------------------------
  logic [7:0] rx_sh_q,  rx_sh_d;
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] tx_sh_q,  tx_sh_d;
  logic [2:0] tx_cnt_q, tx_cnt_d;
  logic [7:0] rx_byte_q, rx_byte_d;
  logic       rx_valid_q, rx_valid_d;
  logic       tx_take_q, tx_take_d;
  logic [3:0] io_q,     io_d;
  logic [3:0] io_oe_q,  io_oe_d;
  logic       sel_q,    paused_q, wp_q;

  // next shift state
  always_comb begin
    logic [3:0] n;
    logic [3:0] sum;
    logic [7:0] src;
    n          = lanes(mode_i);
    sum        = 4'h0;
    src        = tx_sh_q;
    rx_sh_d    = rx_sh_q;
    rx_cnt_d   = rx_cnt_q;
    tx_sh_d    = tx_sh_q;
    tx_cnt_d   = tx_cnt_q;
    rx_byte_d  = rx_byte_q;
    rx_valid_d = 1'b0;
    tx_take_d  = 1'b0;
    io_d       = io_q;
    io_oe_d    = OE_NONE;
    if (!active) begin
      // standby: counters cleared, pins released
      rx_cnt_d = 3'h0;
      tx_cnt_d = 3'h0;
    end else if (!pause) begin
      // receive on rising edge
      if (sck_rise && !tx_dir_i) begin
        unique case (mode_i)
          QNV_SINGLE: rx_sh_d = {rx_sh_q[6:0], s.io[LINE_ZERO]};
          QNV_DUAL:   rx_sh_d = {rx_sh_q[5:0], s.io[1:0]};
          QNV_QUAD:   rx_sh_d = {rx_sh_q[3:0], s.io[3:0]};
          default:    rx_sh_d = rx_sh_q;
        endcase
        sum      = {1'b0, rx_cnt_q} + n;
        rx_cnt_d = sum[2:0];
        if (sum[3]) begin
          rx_byte_d  = rx_sh_d;
          rx_valid_d = 1'b1;
        end
      end
      // transmit on falling edge
      if (sck_fall && tx_dir_i) begin
        if (tx_cnt_q == 3'h0) begin
          src       = tx_byte_i;
          tx_take_d = 1'b1;
        end
        unique case (mode_i)
          QNV_SINGLE: io_d = {2'b00, src[7], 1'b0};
          QNV_DUAL:   io_d = {2'b00, src[7:6]};
          QNV_QUAD:   io_d = src[7:4];
          default:    io_d = io_q;
        endcase
        tx_sh_d  = src << n;
        sum      = {1'b0, tx_cnt_q} + n;
        tx_cnt_d = sum[2:0];
      end
      // drive enables per mode while sending
      if (tx_dir_i) begin
        unique case (mode_i)
          QNV_SINGLE: io_oe_d = OE_SINGLE;
          QNV_DUAL:   io_oe_d = OE_DUAL;
          QNV_QUAD:   io_oe_d = OE_QUAD;
          default:    io_oe_d = OE_NONE;
        endcase
      end
    end
  end

  // shift registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_sh_q    <= BYTE_RST;
      rx_cnt_q   <= 3'h0;
      tx_sh_q    <= BYTE_RST;
      tx_cnt_q   <= 3'h0;
      rx_byte_q  <= BYTE_RST;
      rx_valid_q <= 1'b0;
      tx_take_q  <= 1'b0;
      io_q       <= 4'h0;
      io_oe_q    <= OE_NONE;
      sel_q      <= 1'b0;
      paused_q   <= 1'b0;
      wp_q       <= 1'b0;
    end else begin
      rx_sh_q    <= rx_sh_d;
      rx_cnt_q   <= rx_cnt_d;
      tx_sh_q    <= tx_sh_d;
      tx_cnt_q   <= tx_cnt_d;
      rx_byte_q  <= rx_byte_d;
      rx_valid_q <= rx_valid_d;
      tx_take_q  <= tx_take_d;
      io_q       <= io_d;
      io_oe_q    <= io_oe_d;
      sel_q      <= active;
      paused_q   <= pause;
      wp_q       <= (mode_i != QNV_QUAD) & ~s.io[LINE_TWO];
    end
  end

  // ---------------------------------------------------------------
  // store-busy pin group
  // ---------------------------------------------------------------
  qnv_hsb_st_t          hsb_st_q,  hsb_st_d;
  logic [REL_CNT_W-1:0] rel_cnt_q, rel_cnt_d;
  logic                 hsb_q,     hsb_d;
  logic                 hsb_oe_q,  hsb_oe_d;
  logic                 req_q,     req_d;
  logic                 hsb_fall;

  assign hsb_fall = hsb_prev_q & ~s.store_busy_pin;

  // next store-busy state
  always_comb begin
    hsb_st_d  = hsb_st_q;
    rel_cnt_d = rel_cnt_q;
    req_d     = 1'b0;
    unique case (hsb_st_q)
      HSB_IDLE: begin
        if (store_busy_i) begin
          hsb_st_d = HSB_BUSY;
        end else if (hsb_fall) begin
          req_d = 1'b1;
        end
      end
      HSB_BUSY: begin
        if (store_done_i) begin
          hsb_st_d  = HSB_RELEASE;
          rel_cnt_d = REL_CNT_W'(BUSY_RELEASE_CYC - 1);
        end else if (!store_busy_i) begin
          hsb_st_d = HSB_IDLE;
        end
      end
      HSB_RELEASE: begin
        if (store_busy_i) begin
          hsb_st_d = HSB_BUSY;
        end else if (rel_cnt_q == '0) begin
          hsb_st_d = HSB_IDLE;
        end else begin
          rel_cnt_d = rel_cnt_q - 1'b1;
        end
      end
    endcase
    // low while busy, high while releasing, else weak pull-up
    hsb_oe_d = (hsb_st_d != HSB_IDLE);
    hsb_d    = (hsb_st_d == HSB_RELEASE);
  end

  // store-busy registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hsb_st_q  <= HSB_IDLE;
      rel_cnt_q <= '0;
      hsb_q     <= 1'b1;
      hsb_oe_q  <= 1'b0;
      req_q     <= 1'b0;
    end else begin
      hsb_st_q  <= hsb_st_d;
      rel_cnt_q <= rel_cnt_d;
      hsb_q     <= hsb_d;
      hsb_oe_q  <= hsb_oe_d;
      req_q     <= req_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pins_o         = '{io: io_q, io_oe: io_oe_q, store_busy_pin: hsb_q,
                            store_busy_oe: hsb_oe_q};
  assign tx_take_o      = tx_take_q;
  assign rx_byte_o      = rx_byte_q;
  assign rx_valid_o     = rx_valid_q;
  assign sel_o          = sel_q;
  assign paused_o       = paused_q;
  assign wr_protect_o   = wp_q;
  assign hw_store_req_o = req_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_standby_quiet: assert property (s.cs_n |=> io_oe_q == OE_NONE)
    else $error("data pins driven while deselected");
  a_sel_gates_oe: assert property (!sel_q |-> io_oe_q == OE_NONE)
    else $error("drive while not selected");
  a_pause_freeze: assert property (pause |=> $stable(rx_sh_q) && $stable(io_q))
    else $error("shift moved while paused");
  a_quad_no_pause: assert property (mode_i == QNV_QUAD |=> !paused_q)
    else $error("pause honoured in quad mode");
  a_dual_lanes: assert property (
    active && !pause && tx_dir_i && mode_i == QNV_DUAL |=> io_oe_q == OE_DUAL)
    else $error("dual mode lanes wrong");
  a_single_lane: assert property (
    active && !pause && tx_dir_i && mode_i == QNV_SINGLE |=> io_oe_q == OE_SINGLE)
    else $error("single mode lane wrong");
  a_quad_wp_off: assert property (mode_i == QNV_QUAD |=> !wr_protect_o)
    else $error("write protect active in quad mode");
  a_rise_sample: assert property (
    sck_rise && active && !pause && !tx_dir_i && mode_i == QNV_SINGLE
    |=> rx_sh_q[0] == $past(s.io[0]))
    else $error("input bit not taken on rise");
  a_fall_launch: assert property ($changed(io_q) |-> $past(sck_fall))
    else $error("output changed off a falling edge");
  // state and pin drive move on the same edge, so busy shows one cycle later
  a_busy_low: assert property (
    store_busy_i && !store_done_i |=> hsb_oe_q && !hsb_q)
    else $error("store-busy not pulled low while busy");
  a_release_high: assert property (
    hsb_st_q == HSB_BUSY && store_done_i |=> hsb_oe_q && hsb_q)
    else $error("store-busy not driven high after store");
  a_req_cause: assert property (
    hw_store_req_o |-> $past(hsb_fall) && $past(hsb_st_q) == HSB_IDLE)
    else $error("store request without pin fall");

  c_quad_byte:   cover property (rx_valid_q && mode_i == QNV_QUAD);
  c_hw_request:  cover property (hw_store_req_o);
  c_release:     cover property (hsb_st_q == HSB_RELEASE ##1 hsb_st_q == HSB_IDLE);
  c_paused_send: cover property (paused_q && tx_dir_i);

endmodule

// *** src/qnv_pkg.sv ***
// package for the quad serial nvram pin interface
package qnv_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int BUSY_RELEASE_NS = 50;  // busy_release_drive_time, plain default
  localparam int BUSY_RELEASE_CYC_RAW = BUSY_RELEASE_NS / CLK_PERIOD_NS;
  localparam int BUSY_RELEASE_CYC = (BUSY_RELEASE_CYC_RAW < 1) ? 1 : BUSY_RELEASE_CYC_RAW;
  localparam int REL_CNT_W       = 4;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int BYTE_BITS   = 8;
  localparam int LINE_ZERO   = 0;
  localparam int LINE_ONE    = 1;
  localparam int LINE_TWO    = 2;
  localparam int LINE_THREE  = 3;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hF;
  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {QNV_SINGLE, QNV_DUAL, QNV_QUAD} qnv_mode_t;

  typedef enum logic [1:0] {HSB_IDLE, HSB_BUSY, HSB_RELEASE} qnv_hsb_st_t;

  // pins seen from outside (data_line_three/two double as pause/write-protect)
  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io;
    logic       store_busy_pin;
  } qnv_pin_in_t;

  localparam qnv_pin_in_t PIN_IN_RST = '{sck: 1'b0, cs_n: 1'b1, io: 4'hF,
                                         store_busy_pin: 1'b1};

  // pins driven by the device
  typedef struct packed {
    logic [3:0] io;
    logic [3:0] io_oe;
    logic       store_busy_pin;
    logic       store_busy_oe;
  } qnv_pin_out_t;

endpackage

// *** src/qnv_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module qnv_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // next values of both stages
  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end

  // stage registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      q_o    <= q_d;
    end
  end

endmodule

// *** sim/qnv_host_model.sv ***
// spi host model, clock mode 3, driving the serial pins of the nvram
`timescale 1ns/100ps
module qnv_host_model
  import qnv_pkg::*;
(
  // clock and pin levels
  input  wire logic       clk_i,
  input  wire logic       wp_n_i,
  input  wire logic [3:0] io_i,
  // driven pins
  output logic            sck_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o,
  output logic [3:0]      io_oe_o,
  output logic            holding_o
);
  localparam int HALF = 6;  // sck half period in clk cycles, well above sync delay
  logic [3:0] dat;
  logic       quad;
  logic       pz_n;

  // pause and write-protect ride on lines three and two outside quad
  assign io_o = quad ? dat : {pz_n, wp_n_i, dat[1:0]};

  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    io_oe_o = 4'hC;
    holding_o = 1'b0;
    dat = 4'h0;
    quad = 1'b0;
    pz_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // select or release the device
  task automatic frame(input logic on);
    cs_n_o = ~on;
    if (!on) begin
      io_oe_o = 4'hC;
      quad = 1'b0;
    end
    tick(HALF);
  endtask

  // shift up to eight bits; optional pause with garbage clocks at step hold_at
  task automatic xfer(input qnv_mode_t m, input logic rd, input logic [7:0] tx,
                      input int hold_at, input int bits, output logic [7:0] rx);
    int         w;
    logic [3:0] msk;
    w = (m == QNV_QUAD) ? 4 : (m == QNV_DUAL) ? 2 : 1;
    msk = 4'((1 << w) - 1);
    quad = (m == QNV_QUAD);
    rx = 8'h00;
    io_oe_o = rd ? (quad ? 4'h0 : 4'hC) : (quad ? 4'hF : (4'hC | msk));
    for (int i = 0; i < bits; i += w) begin
      if (i == hold_at) begin
        pz_n = 1'b0;
        holding_o = 1'b1;
        tick(HALF);
        repeat (2) begin
          sck_o = 1'b0;
          dat = ~dat;  // garbage the paused device must not take
          tick(HALF);
          sck_o = 1'b1;
          tick(HALF);
        end
        pz_n = 1'b1;
        holding_o = 1'b0;
        tick(HALF);
      end
      sck_o = 1'b0;  // host launches on the fall
      dat = 4'(tx >> (8 - w - i)) & msk;
      tick(HALF);
      sck_o = 1'b1;  // both sides take data on the rise
      rx = (rx << w) | 8'((w == 1) ? {3'h0, io_i[1]} : (io_i & msk));
      tick(HALF);
    end
  endtask
endmodule

// *** sim/qnv_pin_if_bench.sv ***
// self-checking bench for the nvram pin front end
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module qnv_pin_if_bench
  import qnv_pkg::*;
;
  logic clk = 1'b0, srst, tx_dir, st_busy, st_done, ext_low, wp_n, flip = 1'b0;
  logic rx_valid, sel, paused, wr_prot, req, tx_take, sck, cs_n, hold, sb_w;
  logic [7:0] tx_byte, rx_byte, b, r, exp_b, expq[$];
  logic [3:0] h_io, h_oe, io_w;
  qnv_mode_t    mode;
  qnv_pin_in_t  pin_in;
  qnv_pin_out_t po;
  int seed, n_fail = 0, samples_checked = 0, n_req = 0, n_take = 0, hi, n0;

  always #20 clk = ~clk;
  always @(posedge clk) flip <= ~flip;

  // released lines show a changing pattern, store-busy has a pull-up
  assign io_w = (po.io_oe & po.io) | (~po.io_oe & h_oe & h_io) | (~po.io_oe & ~h_oe & {4{flip}});
  assign sb_w = po.store_busy_oe ? po.store_busy_pin : ~ext_low;
  assign pin_in = '{sck: sck, cs_n: cs_n, io: io_w, store_busy_pin: sb_w};

  qnv_host_model h (.clk_i(clk), .wp_n_i(wp_n), .io_i(io_w), .sck_o(sck), .cs_n_o(cs_n),
                    .io_o(h_io), .io_oe_o(h_oe), .holding_o(hold));

  qnv_pin_if DUT (.clk_i(clk), .srst_i(srst), .pins_i(pin_in), .pins_o(po), .mode_i(mode),
                  .tx_dir_i(tx_dir), .tx_byte_i(tx_byte), .tx_take_o(tx_take),
                  .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .sel_o(sel),
                  .paused_o(paused), .wr_protect_o(wr_prot), .store_busy_i(st_busy),
                  .store_done_i(st_done), .hw_store_req_o(req));

  // received bytes against the oldest note
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      exp_b = (expq.size() != 0) ? expq.pop_front() : 8'hXX;
      `CHK(rx_byte, exp_b)
    end
    if (req === 1'b1) n_req++;
    if (tx_take === 1'b1) n_take++;
  end

  // paused flag while the host holds the pause line low
  initial forever begin
    @(posedge hold);
    repeat (5) @(negedge clk);
    `CHK(paused, 1'b1)
    `CHK(po.io_oe, OE_NONE)
  end

  task automatic close_out();
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    close_out();
  end

  initial begin
    {srst, tx_dir, st_busy, st_done, ext_low, wp_n} = 6'h21;
    mode = QNV_SINGLE;
    tx_byte = 8'h00;
    seed = 72583;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    // partial byte then deselect: nothing may come out
    h.frame(1'b1);
    h.xfer(QNV_SINGLE, 1'b0, 8'hA5, 99, 4, r);
    h.frame(1'b0);
    // receive two bytes per frame in every mode, paused mid-byte outside quad
    for (int m = 0; m < 3; m++) begin
      mode = qnv_mode_t'(m);
      h.frame(1'b1);
      `CHK(sel, 1'b1)
      for (int k = 0; k < 2; k++) begin
        b = 8'($random(seed));
        expq.push_back(b);
        h.xfer(mode, 1'b0, b, (k == 1 && m < 2) ? 4 : 99, 8, r);
      end
      h.frame(1'b0);
      `CHK(sel, 1'b0)
    end
    // send one byte per mode, paused mid-byte outside quad, and check the drive mask
    tx_dir = 1'b1;
    for (int m = 0; m < 3; m++) begin
      mode = qnv_mode_t'(m);
      b = 8'($random(seed));
      tx_byte = b;
      h.frame(1'b1);
      h.xfer(mode, 1'b1, 8'h00, (m < 2) ? 4 : 99, 8, r);
      `CHK(r, b)
      `CHK(po.io_oe, (m == 0) ? OE_SINGLE : (m == 1) ? OE_DUAL : OE_QUAD)
      h.frame(1'b0);
      `CHK(po.io_oe, OE_NONE)
    end
    `CHK(n_take, 3)
    tx_dir = 1'b0;
    // write-protect honoured only outside quad: first low, then a random level
    for (int m = 0; m < 3; m++) begin
      mode = qnv_mode_t'(m);
      for (int k = 0; k < 2; k++) begin
        wp_n = (k == 0) ? 1'b0 : 1'($random(seed));
        repeat (5) @(negedge clk);
        `CHK(wr_prot, (m != 2) && !wp_n)
      end
    end
    wp_n = 1'b1;
    // store: low while busy, outside low refused, brief high drive after done
    n0 = n_req;
    st_busy = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(sb_w, 1'b0)
    ext_low = 1'b1;
    repeat (6) @(negedge clk);
    ext_low = 1'b0;
    repeat (4) @(negedge clk);
    st_done = 1'b1;
    @(negedge clk);
    {st_done, st_busy} = 2'b00;
    // the high drive already stands at this edge
    hi = int'(po.store_busy_oe && po.store_busy_pin);
    repeat (6) begin
      @(negedge clk);
      hi += int'(po.store_busy_oe && po.store_busy_pin);
    end
    `CHK(hi, BUSY_RELEASE_CYC)
    `CHK(po.store_busy_oe, 1'b0)
    `CHK(n_req, n0)
    // recall: low while busy, then release without high drive
    st_busy = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(sb_w, 1'b0)
    st_busy = 1'b0;
    hi = 0;
    repeat (6) begin
      @(negedge clk);
      hi += int'(po.store_busy_oe && po.store_busy_pin);
    end
    `CHK(hi, 0)
    // outside low while idle requests a store once
    ext_low = 1'b1;
    repeat (8) @(negedge clk);
    ext_low = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(n_req, n0 + 1)
    `CHK(expq.size(), 0)
    close_out();
  end
endmodule
